//--- verilog/dtc_pkg.sv
/*
  constants for the debug transport control and status register:
  tap instruction codes, register field positions, reset values and status codes.
  assumes the tap is driven by an external debugger over tck/tms/tdi/tdo.
*/
// Contract
// RULE_01: error detail codes zero to four, rest reserved
// RULE_02: error detail refreshed on status update or clear
// RULE_03: error detail resets to four, unknown
// RULE_04: full reset abandons transactions, resets all state
// RULE_05: debugger uses full reset only for hung transactions
// RULE_06: sticky clear resets error, keeps transactions running
// RULE_07: preset idle hint reports needed idle cycles
// RULE_08: debugger still checks mirrored status for busy
// RULE_09: status mirror always equals access operation status
// RULE_10: address width field reports preset address bits
// RULE_11: version field reads one after reset
// RULE_12: register width never changes between versions
// RULE_13: failed status sticky until sticky clear written
// RULE_14: instruction 0x10 selects this register
// RULE_15: action bits ignore zero and read zero
package dtc_pkg;
  localparam int unsigned  IR_W          = 5;
  localparam logic [4:0]   IR_CSR        = 5'h10;
  localparam logic [4:0]   IR_RESET      = 5'h01;
  localparam int unsigned  CSR_W         = 32;
  // field positions
  localparam int unsigned  F_VERSION_LSB = 0;
  localparam int unsigned  F_ABITS_LSB   = 4;
  localparam int unsigned  F_STAT_LSB    = 10;
  localparam int unsigned  F_IDLE_LSB    = 12;
  localparam int unsigned  F_CLEAR_BIT   = 16;
  localparam int unsigned  F_HARD_BIT    = 17;
  localparam int unsigned  F_ERR_LSB     = 18;
  // values
  localparam logic [3:0]   VERSION_RESET = 4'h1;
  localparam logic [1:0]   OP_SUCCESS    = 2'h0;
  localparam logic [1:0]   OP_FAILED     = 2'h2;
  localparam logic [1:0]   OP_BUSY       = 2'h3;
  localparam logic [2:0]   ERR_NONE_IMPL = 3'h0;
  localparam logic [2:0]   ERR_DMI       = 3'h1;
  localparam logic [2:0]   ERR_COMM      = 3'h2;
  localparam logic [2:0]   ERR_DEVICE    = 3'h3;
  localparam logic [2:0]   ERR_UNKNOWN   = 3'h4;
  localparam int unsigned  SYNC_STAGES   = 3;

  typedef enum logic [3:0] {
    DTC_TLR    = 4'h0,
    DTC_RTI    = 4'h1,
    DTC_SELDR  = 4'h2,
    DTC_CAPDR  = 4'h3,
    DTC_SHDR   = 4'h4,
    DTC_EX1DR  = 4'h5,
    DTC_PADR   = 4'h6,
    DTC_EX2DR  = 4'h7,
    DTC_UPDR   = 4'h8,
    DTC_SELIR  = 4'h9,
    DTC_CAPIR  = 4'hA,
    DTC_SHIR   = 4'hB,
    DTC_EX1IR  = 4'hC,
    DTC_PAIR   = 4'hD,
    DTC_EX2IR  = 4'hE,
    DTC_UPIR   = 4'hF
  } dtc_tap_t;
endpackage

//--- verilog/dtc_sync.sv
/*
  three stage synchroniser for pins from outside the i_mclk domain.
  assumes inputs are plain levels; stage one is read only by stage two.
*/
`timescale 1ns/1ps
module dtc_sync #(
  parameter int unsigned W = 3
) (
  // clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_rst_n,
  input  wire logic         i_ce,
  // pins in, stages two and three out
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_s2,
  output logic      [W-1:0] o_s3
);
  logic [W-1:0] s1;

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s1   <= '0;
      o_s2 <= '0;
      o_s3 <= '0;
    end
    else if (i_ce)
    begin
      s1   <= i_async;
      o_s2 <= s1;
      o_s3 <= o_s2;
    end
  end
endmodule

//--- verilog/dtc_csr.sv
/*
  tap controller, instruction register and the transport control and status
  data register, plus the sticky access status and error detail it mirrors.
  assumes tck is much slower than i_mclk (sampled, edges found here) and that
  the access scan logic reports status updates as one-cycle pulses on i_mclk.
*/
`timescale 1ns/1ps
module dtc_csr #(
  parameter logic [5:0] ABITS = 6'h07,
  parameter logic [2:0] IDLE  = 3'h1
) (
  // clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic       i_ce,
  // tap pins
  input  wire logic       i_tck,
  input  wire logic       i_tms,
  input  wire logic       i_tdi,
  output logic            o_tdo,
  output logic            o_tdo_oe,
  // access scan status from the interface side
  input  wire logic       i_op_update,
  input  wire logic [1:0] i_op_status,
  input  wire logic [2:0] i_op_errinfo,
  // status and actions back to the interface side
  output logic [1:0]      o_access_operation,
  output logic            o_op_sticky,
  output logic            o_transport_reset,
  output logic            o_sticky_clear,
  output logic [4:0]      o_ir
);
  dtc_pkg::dtc_tap_t state;
  dtc_pkg::dtc_tap_t next_state;
  logic [2:0]  pin_s2;
  logic [2:0]  pin_s3;
  logic        tck_lvl;
  logic        tms_lvl;
  logic        tdi_lvl;
  logic [4:0]  ir_sh;
  logic [4:0]  next_ir_sh;
  logic [4:0]  next_ir;
  logic [31:0] dr_sh;
  logic [31:0] next_dr_sh;
  logic        next_tdo;
  logic        next_tdo_oe;
  logic        next_hard;
  logic        next_clear;
  logic [1:0]  op;
  logic [1:0]  next_op;
  logic [2:0]  err;
  logic [2:0]  next_err;
  logic [31:0] csr_value;
  logic        tck_rise;
  logic        tck_fall;
  logic        csr_sel;

  function automatic dtc_pkg::dtc_tap_t tap_next(input dtc_pkg::dtc_tap_t s, input logic tms);
    case (s)
      dtc_pkg::DTC_TLR:   tap_next = tms ? dtc_pkg::DTC_TLR   : dtc_pkg::DTC_RTI;
      dtc_pkg::DTC_RTI:   tap_next = tms ? dtc_pkg::DTC_SELDR : dtc_pkg::DTC_RTI;
      dtc_pkg::DTC_SELDR: tap_next = tms ? dtc_pkg::DTC_SELIR : dtc_pkg::DTC_CAPDR;
      dtc_pkg::DTC_CAPDR: tap_next = tms ? dtc_pkg::DTC_EX1DR : dtc_pkg::DTC_SHDR;
      dtc_pkg::DTC_SHDR:  tap_next = tms ? dtc_pkg::DTC_EX1DR : dtc_pkg::DTC_SHDR;
      dtc_pkg::DTC_EX1DR: tap_next = tms ? dtc_pkg::DTC_UPDR  : dtc_pkg::DTC_PADR;
      dtc_pkg::DTC_PADR:  tap_next = tms ? dtc_pkg::DTC_EX2DR : dtc_pkg::DTC_PADR;
      dtc_pkg::DTC_EX2DR: tap_next = tms ? dtc_pkg::DTC_UPDR  : dtc_pkg::DTC_SHDR;
      dtc_pkg::DTC_UPDR:  tap_next = tms ? dtc_pkg::DTC_SELDR : dtc_pkg::DTC_RTI;
      dtc_pkg::DTC_SELIR: tap_next = tms ? dtc_pkg::DTC_TLR   : dtc_pkg::DTC_CAPIR;
      dtc_pkg::DTC_CAPIR: tap_next = tms ? dtc_pkg::DTC_EX1IR : dtc_pkg::DTC_SHIR;
      dtc_pkg::DTC_SHIR:  tap_next = tms ? dtc_pkg::DTC_EX1IR : dtc_pkg::DTC_SHIR;
      dtc_pkg::DTC_EX1IR: tap_next = tms ? dtc_pkg::DTC_UPIR  : dtc_pkg::DTC_PAIR;
      dtc_pkg::DTC_PAIR:  tap_next = tms ? dtc_pkg::DTC_EX2IR : dtc_pkg::DTC_PAIR;
      dtc_pkg::DTC_EX2IR: tap_next = tms ? dtc_pkg::DTC_UPIR  : dtc_pkg::DTC_SHIR;
      dtc_pkg::DTC_UPIR:  tap_next = tms ? dtc_pkg::DTC_SELDR : dtc_pkg::DTC_RTI;
      default:            tap_next = dtc_pkg::DTC_TLR;
    endcase
  endfunction

  dtc_sync #(
    .W (3)
  ) u_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_async ({i_tck, i_tms, i_tdi}),
    .o_s2    (pin_s2),
    .o_s3    (pin_s3)
  );

  // a pin level is accepted only once stages two and three agree
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tck_lvl <= 1'b0;
      tms_lvl <= 1'b1;
      tdi_lvl <= 1'b0;
    end
    else if (i_ce)
    begin
      if (pin_s2[2] == pin_s3[2])
        tck_lvl <= pin_s3[2];
      if (pin_s2[1] == pin_s3[1])
        tms_lvl <= pin_s3[1];
      if (pin_s2[0] == pin_s3[0])
        tdi_lvl <= pin_s3[0];
    end
  end

  assign tck_rise = i_ce && pin_s2[2] && pin_s3[2] && !tck_lvl;
  assign tck_fall = i_ce && !pin_s2[2] && !pin_s3[2] && tck_lvl;
  assign csr_sel  = (o_ir == dtc_pkg::IR_CSR); // RULE_14

  // fixed width; action bits always read zero
  always_comb
  begin
    csr_value = '0; // RULE_12 RULE_15
    csr_value[dtc_pkg::F_VERSION_LSB +: 4] = dtc_pkg::VERSION_RESET; // RULE_11
    csr_value[dtc_pkg::F_ABITS_LSB +: 6]   = ABITS; // RULE_10
    csr_value[dtc_pkg::F_STAT_LSB +: 2]    = op; // RULE_09
    csr_value[dtc_pkg::F_IDLE_LSB +: 3]    = IDLE; // RULE_07
    csr_value[dtc_pkg::F_ERR_LSB +: 3]     = err; // RULE_01
  end

  always_comb
  begin
    next_state  = state;
    next_ir     = o_ir;
    next_ir_sh  = ir_sh;
    next_dr_sh  = dr_sh;
    next_tdo    = o_tdo;
    next_tdo_oe = o_tdo_oe;
    next_hard   = 1'b0;
    next_clear  = 1'b0;
    if (tck_rise)
    begin
      next_state = tap_next(state, tms_lvl);
      case (state)
        dtc_pkg::DTC_TLR:   next_ir = dtc_pkg::IR_RESET;
        dtc_pkg::DTC_CAPIR: next_ir_sh = dtc_pkg::IR_RESET;
        dtc_pkg::DTC_SHIR:  next_ir_sh = {tdi_lvl, ir_sh[4:1]};
        dtc_pkg::DTC_UPIR:  next_ir = ir_sh;
        dtc_pkg::DTC_CAPDR: next_dr_sh = csr_sel ? csr_value : 32'h00000000; // RULE_14
        dtc_pkg::DTC_SHDR:
        begin
          if (csr_sel)
            next_dr_sh = {tdi_lvl, dr_sh[31:1]};
          else
            next_dr_sh = {31'h00000000, tdi_lvl};
        end
        dtc_pkg::DTC_UPDR:
        begin
          // only a one acts; a zero written is ignored
          next_hard  = csr_sel && dr_sh[dtc_pkg::F_HARD_BIT]; // RULE_04 RULE_15
          next_clear = csr_sel && dr_sh[dtc_pkg::F_CLEAR_BIT]; // RULE_06 RULE_15
        end
        default:
        begin
          next_dr_sh = dr_sh;
        end
      endcase
    end
    if (tck_fall)
    begin
      next_tdo_oe = (state == dtc_pkg::DTC_SHIR) || (state == dtc_pkg::DTC_SHDR);
      next_tdo    = (state == dtc_pkg::DTC_SHIR) ? ir_sh[0] : dr_sh[0];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state             <= dtc_pkg::DTC_TLR;
      o_ir              <= dtc_pkg::IR_RESET;
      ir_sh             <= dtc_pkg::IR_RESET;
      dr_sh             <= 32'h00000000;
      o_tdo             <= 1'b0;
      o_tdo_oe          <= 1'b0;
      o_transport_reset <= 1'b0;
      o_sticky_clear    <= 1'b0;
    end
    else if (i_ce)
    begin
      state             <= next_state;
      o_ir              <= next_ir;
      ir_sh             <= next_ir_sh;
      dr_sh             <= next_dr_sh;
      o_tdo             <= next_tdo;
      o_tdo_oe          <= next_tdo_oe;
      o_transport_reset <= next_hard;
      o_sticky_clear    <= next_clear;
    end
  end

  // status: full reset beats everything; a new failure beats a same-cycle clear
  always_comb
  begin
    next_op  = op;
    next_err = err;
    if (o_transport_reset)
    begin
      next_op  = dtc_pkg::OP_SUCCESS; // RULE_04
      next_err = dtc_pkg::ERR_UNKNOWN; // RULE_04
    end
    else
    begin
      if (o_sticky_clear)
      begin
        next_op  = dtc_pkg::OP_SUCCESS; // RULE_06
        next_err = dtc_pkg::ERR_UNKNOWN; // RULE_02
      end
      if (i_op_update && (op != dtc_pkg::OP_FAILED || o_sticky_clear)) // RULE_13
      begin
        next_op  = i_op_status;
        next_err = (i_op_errinfo > dtc_pkg::ERR_UNKNOWN) ? dtc_pkg::ERR_UNKNOWN : i_op_errinfo; // RULE_01 RULE_02
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      op  <= dtc_pkg::OP_SUCCESS;
      err <= dtc_pkg::ERR_UNKNOWN; // RULE_03
    end
    else if (i_ce)
    begin
      op  <= next_op;
      err <= next_err;
    end
  end

  assign o_access_operation = op;
  assign o_op_sticky        = (op == dtc_pkg::OP_FAILED); // RULE_13

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  csr_capture_a: assert property ( // RULE_14
      tck_rise && state == dtc_pkg::DTC_CAPDR && csr_sel |=> dr_sh == $past(csr_value))
    else $error("selected register not captured");
  stat_mirror_a: assert property ( // RULE_09
      tck_rise && state == dtc_pkg::DTC_CAPDR && csr_sel |=> dr_sh[dtc_pkg::F_STAT_LSB +: 2] == $past(op))
    else $error("captured status differs from access status");
  hard_reset_a: assert property ( // RULE_04
      i_ce && o_transport_reset |=> op == dtc_pkg::OP_SUCCESS && err == dtc_pkg::ERR_UNKNOWN)
    else $error("full reset left status set");
  sticky_clear_a: assert property ( // RULE_06
      i_ce && o_sticky_clear && !i_op_update |=> op == dtc_pkg::OP_SUCCESS && err == dtc_pkg::ERR_UNKNOWN)
    else $error("sticky clear did not reset status");
  sticky_hold_a: assert property ( // RULE_13
      i_ce && op == dtc_pkg::OP_FAILED && !o_sticky_clear && !o_transport_reset
      |=> op == dtc_pkg::OP_FAILED && $stable(err))
    else $error("failed status lost without clear");
  err_update_a: assert property ( // RULE_02
      i_ce && i_op_update && op != dtc_pkg::OP_FAILED && !o_transport_reset
      && i_op_errinfo <= dtc_pkg::ERR_UNKNOWN |=> err == $past(i_op_errinfo))
    else $error("error detail not refreshed on update");
  err_range_a: assert property (err <= dtc_pkg::ERR_UNKNOWN) // RULE_01
    else $error("error detail holds reserved code");
  // checked on the captured shift register, so a broken capture path trips it
  const_fields_a: assert property ( // RULE_11
      tck_rise && state == dtc_pkg::DTC_CAPDR && csr_sel
      |=> dr_sh[dtc_pkg::F_VERSION_LSB +: 4] == dtc_pkg::VERSION_RESET
      && dr_sh[dtc_pkg::F_ABITS_LSB +: 6] == ABITS && dr_sh[dtc_pkg::F_IDLE_LSB +: 3] == IDLE)
    else $error("preset fields wrong");
  action_zero_a: assert property ( // RULE_15
      tck_rise && state == dtc_pkg::DTC_CAPDR && csr_sel
      |=> dr_sh[dtc_pkg::F_HARD_BIT] == 1'b0 && dr_sh[dtc_pkg::F_CLEAR_BIT] == 1'b0)
    else $error("action bits read back nonzero");
endmodule

//--- dv/dtc_dbg_model.sv
/*
  behavioural debugger on the tap pins: walks the tap state machine, shifts ir or dr.
  assumes nothing of the i_mclk phase; tck rests low between scans.
*/
`timescale 1ns/1ps
module dtc_dbg_model (
  // tap pins
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi,
  input  wire logic i_tdo
);
  initial
  begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end

  // one 125 ns tck period; tdo is taken just before the rise
  task automatic step(input logic m, input logic d, output logic q);
    o_tms = m;
    o_tdi = d;
    #62.5;
    q = i_tdo;
    o_tck = 1'b1;
    #62.5;
    o_tck = 1'b0;
  endtask

  task automatic tlr();
    logic q;
    #3;
    repeat (5)
      step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask

  // idle to idle through one scan; tdi shows the inverse once released
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic q;
    dout = 32'h0;
    #3;
    step(1'b1, 1'b0, q);
    if (ir)
      step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, ~din[n - 1], q);
    // idle entered and left at once, as the hint of one allows
    step(1'b0, ~din[n - 1], q);
  endtask
endmodule

//--- dv/test_debug_transport_ctrl_status.sv
/*
  self-checking bench for dtc_csr: a debugger model scans the register while
  the bench plays the access scan logic on the status port.
  assumes the package and design files are compiled first.
*/
`timescale 1ns/1ps
module test_debug_transport_ctrl_status;
  localparam logic [5:0] ABITS = 6'h07;
  localparam logic [2:0] IDLE  = 3'h1;
  logic        i_mclk       = 1'b0;
  logic        i_rst_n      = 1'b0;
  logic        i_ce         = 1'b1;
  logic        i_op_update  = 1'b0;
  logic [1:0]  i_op_status  = 2'h0;
  logic [2:0]  i_op_errinfo = 3'h4;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic        tdo;
  logic        tdo_oe;
  logic [1:0]  acc_op;
  logic        sticky;
  logic        hard_p;
  logic        clr_p;
  logic [4:0]  ir;
  logic [31:0] rd;
  int          n_errors = 0;
  int          n_tests  = 0;
  int          n_clr    = 0;
  int          n_hrd    = 0;
  int          m_stat   = 0;
  int          m_err    = 4;

  always #5 i_mclk = ~i_mclk;

  // counted on every rising edge so a doubled pulse shows up
  always @(posedge i_mclk)
  begin
    if (clr_p === 1'b1)
      n_clr <= n_clr + 1;
    if (hard_p === 1'b1)
      n_hrd <= n_hrd + 1;
  end

  dtc_csr #(.ABITS(ABITS), .IDLE(IDLE)) uut (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe),
    .i_op_update(i_op_update), .i_op_status(i_op_status), .i_op_errinfo(i_op_errinfo),
    .o_access_operation(acc_op), .o_op_sticky(sticky),
    .o_transport_reset(hard_p), .o_sticky_clear(clr_p), .o_ir(ir)
  );

  dtc_dbg_model dbg (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo));

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t ns: %s is %h, expected %h", $time, what, got, exp);
    end
  endtask

  task automatic upd(input int st, input int er);
    @(posedge i_mclk);
    i_op_update  <= 1'b1;
    i_op_status  <= st[1:0];
    i_op_errinfo <= er[2:0];
    @(posedge i_mclk);
    i_op_update  <= 1'b0;
    if (m_stat != 2)
    begin
      m_stat = st;
      m_err  = (er > 4) ? 4 : er;
    end
    repeat (2) @(posedge i_mclk);
    #1;
    check({30'h0, acc_op}, m_stat, "status");
    check({31'h0, sticky}, m_stat == 2, "sticky");
  endtask

  // the read shows the state before the scan; action bits act afterwards
  task automatic dr(input logic [31:0] wr);
    int c0;
    int h0;
    c0 = n_clr;
    h0 = n_hrd;
    @(posedge i_mclk);
    dbg.scan(1'b0, 32, wr, rd);
    check(rd, {11'h0, m_err[2:0], 3'h0, IDLE, m_stat[1:0], ABITS, 4'h1}, "csr");
    if (wr[17] || wr[16])
    begin
      m_stat = 0;
      m_err  = 4;
    end
    check(n_clr - c0, wr[16], "clear pulses");
    check(n_hrd - h0, wr[17], "reset pulses");
    check({30'h0, acc_op}, m_stat, "status after scan");
    check({31'h0, tdo_oe}, 32'h0, "tdo enable idle");
  endtask

  task automatic results();
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    int          e;
    int          c;
    logic [31:0] w;
    void'($urandom(32'hB2D7));
    repeat (10) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_mclk);
    #1;
    check({27'h0, ir}, 32'h01, "ir after reset");
    dbg.tlr();
    @(posedge i_mclk);
    dbg.scan(1'b1, 5, 32'h10, rd);
    check(rd, 32'h01, "ir capture");
    check({27'h0, ir}, 32'h10, "ir");
    dr(32'h0);
    dr($urandom & 32'hFFFC_FFFF);
    $display("test reset_values done");
    for (e = 1; e <= 4; e++)
    begin
      upd(0, e);
      dr(32'h0);
    end
    upd(0, 5 + $urandom % 3);
    dr(32'h0);
    $display("test error_codes done");
    upd(2, 3);
    upd(0, 1);
    dr(32'h0);
    dr(32'h0001_0000);
    upd(3, 1 + $urandom % 4);
    dr(32'h0);
    $display("test sticky_clear done");
    upd(2, 2);
    dr(32'h0002_0000);
    dr(32'h0);
    $display("test full_reset done");
    dbg.tlr();
    check({27'h0, ir}, 32'h01, "ir after tap reset");
    $display("test tap_reset done");
    // unselected instructions shift through a one-bit bypass and never act
    c = n_clr + n_hrd;
    w = $urandom;
    @(posedge i_mclk);
    dbg.scan(1'b0, 32, w, rd);
    check(rd, {w[30:0], 1'b0}, "bypass data");
    check(n_clr + n_hrd, c, "pulses in bypass");
    $display("test bypass done");
    // a low enable freezes the status even against an update
    @(posedge i_mclk);
    i_ce         <= 1'b0;
    i_op_update  <= 1'b1;
    i_op_status  <= 2'h2;
    @(posedge i_mclk);
    i_op_update  <= 1'b0;
    @(posedge i_mclk);
    i_ce         <= 1'b1;
    repeat (2) @(posedge i_mclk);
    #1;
    check({30'h0, acc_op}, m_stat, "status under low enable");
    check({31'h0, sticky}, 32'h0, "sticky under low enable");
    $display("test clock_enable done");
    results();
  end
endmodule
